// file: hdl/can_buffer_half.sv
// One buffer's control byte with hardware set and clear behaviour
`include "can_pair_params.svh"
module can_buffer_half
  import can_pair_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Software write of this byte
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Engine results for this buffer
  input wire engine_evt_t evt,
  // Current byte
  output half_ctrl_t ctrl,
  output logic abort_req
);
  half_ctrl_t next_ctrl;
  logic req_set;

  always_comb begin
    next_ctrl = ctrl;
    req_set = 1'b0;
    if (wr_en) begin
      next_ctrl.dir_tx = wr_data[`POS_DIR];
      next_ctrl.auto_rtr = wr_data[`POS_AUTO_RTR];
      next_ctrl.pri = wr_data[`POS_PRI_HI:`POS_PRI_LO];
      // Zero over a set request stays set until abort or successful send completes
      if (wr_data[`POS_SEND_REQ]) begin
        req_set = 1'b1;
      end
    end
    if (evt.rtr_rx && ctrl.auto_rtr) begin
      req_set = 1'b1;
    end
    if (evt.done_ok) begin
      next_ctrl.send_req = 1'b0;
      next_ctrl.aborted = 1'b0;
    end
    if (evt.aborted) begin
      next_ctrl.send_req = 1'b0;
      next_ctrl.aborted = 1'b1;
    end
    if (evt.lost_arb) begin
      next_ctrl.lost_arb = 1'b1;
    end
    if (evt.bus_err) begin
      next_ctrl.tx_err = 1'b1;
    end
    if (req_set) begin
      next_ctrl.send_req = 1'b1;
      next_ctrl.aborted = 1'b0;
      next_ctrl.lost_arb = 1'b0;
      next_ctrl.tx_err = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= half_ctrl_t'(`RST_HALF);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Abort stays requested while software has written zero to a pending one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_req <= 1'b0;
    end else if (!ctrl.send_req || evt.done_ok || evt.aborted) begin
      abort_req <= 1'b0;
    end else if (wr_en && !wr_data[`POS_SEND_REQ]) begin
      abort_req <= 1'b1;
    end
  end
endmodule : can_buffer_half

// file: hdl/can_buffer_pair_control.sv
// Control register, engine hand-off and AXI4-Lite slave for a buffer pair
//
// Summary of operation
// - One 16-bit register, odd buffer high byte
// - Bit 7 selects transmit or receive
// - Bit 6 read-only, set on abort
// - Bit 5 read-only, lost arbitration
// - Bit 4 read-only, bus error while sending
// - Setting send request clears the three flags
// - Successful send clears send request
// - Writing zero while pending requests abort
// - Auto-reply enable sets request on remote frame
// - Bits 1-0 give priority, 11 highest
// - Message contents live in DMA RAM
`include "can_pair_params.svh"
module can_buffer_pair_control
  import can_pair_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine, index 0 even buffer, 1 odd buffer
  input wire engine_evt_t evt_even,
  input wire engine_evt_t evt_odd,
  output logic tx_offer_valid,
  output logic tx_offer_sel,
  output logic [1:0] tx_offer_pri,
  output logic [1:0] abort_req,
  // Interrupt
  output logic irq
);
  half_ctrl_t ctrl_even;
  half_ctrl_t ctrl_odd;
  logic [1:0] abort_int;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] irq_events;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic wr_ctrl;
  logic wr_even;
  logic wr_odd;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic next_offer_valid;
  logic next_offer_sel;
  arb_state_t arb_state;

  // Message contents sit in DMA RAM; only control lives here.

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = do_write && (aw_addr[7:2] == `OFS_PAIR_CTRL >> 2);
  assign wr_even = wr_ctrl && w_strb[0];
  assign wr_odd = wr_ctrl && w_strb[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr[7:2])
        `OFS_PAIR_CTRL >> 2, `OFS_IRQ_STATUS >> 2,
        `OFS_IRQ_MASK >> 2, `OFS_ENGINE >> 2: s_axi_bresp <= `AXI_OKAY;
        default: s_axi_bresp <= `AXI_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  can_buffer_half u_even (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_even),
    .wr_data(w_data[7:0]),
    .evt(evt_even),
    .ctrl(ctrl_even),
    .abort_req(abort_int[0])
  );

  can_buffer_half u_odd (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_odd),
    .wr_data(w_data[15:8]),
    .evt(evt_odd),
    .ctrl(ctrl_odd),
    .abort_req(abort_int[1])
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_req <= 2'b00;
    end else begin
      abort_req <= abort_int;
    end
  end

  // Status: [3:0] even done/abort/arb/err, [7:4] same for odd
  assign irq_events = {evt_odd.done_ok, evt_odd.aborted, evt_odd.lost_arb,
                       evt_odd.bus_err, evt_even.done_ok, evt_even.aborted,
                       evt_even.lost_arb, evt_even.bus_err};

  // Set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (irq_events[i]) begin
          irq_status[i] <= 1'b1;
        end else if (do_write && w_strb[0] && w_data[i] &&
                     aw_addr[7:2] == `OFS_IRQ_STATUS >> 2) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= `RST_MASK;
    end else if (do_write && w_strb[0] &&
                 aw_addr[7:2] == `OFS_IRQ_MASK >> 2) begin
      irq_mask <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Offer choice among pending transmit buffers
  always_comb begin
    next_offer_valid = 1'b0;
    next_offer_sel = 1'b0;
    if (ctrl_even.send_req && ctrl_even.dir_tx && ctrl_odd.send_req &&
        ctrl_odd.dir_tx) begin
      next_offer_valid = 1'b1;
      next_offer_sel = ctrl_odd.pri > ctrl_even.pri;
    end else if (ctrl_odd.send_req && ctrl_odd.dir_tx) begin
      next_offer_valid = 1'b1;
      next_offer_sel = 1'b1;
    end else if (ctrl_even.send_req && ctrl_even.dir_tx) begin
      next_offer_valid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arb_state <= ARB_IDLE;
    end else begin
      arb_state <= next_offer_valid ? ARB_BUSY : ARB_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_offer_valid <= 1'b0;
      tx_offer_sel <= 1'b0;
      tx_offer_pri <= 2'b00;
    end else begin
      tx_offer_valid <= next_offer_valid;
      tx_offer_sel <= next_offer_sel;
      tx_offer_pri <= next_offer_sel ? ctrl_odd.pri : ctrl_even.pri;
    end
  end

  // Read path
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    case (s_axi_araddr[7:2])
      `OFS_PAIR_CTRL >> 2: next_rdata[15:0] = {ctrl_odd, ctrl_even};
      `OFS_IRQ_STATUS >> 2: next_rdata[7:0] = irq_status;
      `OFS_IRQ_MASK >> 2: next_rdata[7:0] = irq_mask;
      `OFS_ENGINE >> 2: next_rdata[4:0] = {abort_int, tx_offer_pri,
                                            arb_state == ARB_BUSY};
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? `AXI_SLVERR : `AXI_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : can_buffer_pair_control

// file: hdl/can_pair_params.svh
// Offsets, field positions and reset values for the buffer pair block
`ifndef CAN_PAIR_PARAMS_SVH
`define CAN_PAIR_PARAMS_SVH
`define OFS_PAIR_CTRL 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_ENGINE 8'h0C
`define POS_DIR 7
`define POS_ABORTED 6
`define POS_LOST_ARB 5
`define POS_TX_ERR 4
`define POS_SEND_REQ 3
`define POS_AUTO_RTR 2
`define POS_PRI_HI 1
`define POS_PRI_LO 0
`define RST_HALF 8'h00
`define RST_MASK 8'h00
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

// file: hdl/can_pair_pkg.sv
// Types shared by the buffer pair control block
package can_pair_pkg;
  // One byte of the pair control register
  typedef struct packed {
    logic dir_tx;
    logic aborted;
    logic lost_arb;
    logic tx_err;
    logic send_req;
    logic auto_rtr;
    logic [1:0] pri;
  } half_ctrl_t;

  // Outcome reported by the protocol engine for one buffer
  typedef struct packed {
    logic done_ok;
    logic aborted;
    logic lost_arb;
    logic bus_err;
    logic rtr_rx;
  } engine_evt_t;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_BUSY = 2'b01
  } arb_state_t;
endpackage : can_pair_pkg

// file: verif/can_buffer_pair_control_sva.sv
// Port assertions for the buffer pair control block
`include "can_pair_params.svh"
module can_buffer_pair_control_sva
  import can_pair_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  // Engine and interrupt
  input wire engine_evt_t evt_even,
  input wire engine_evt_t evt_odd,
  input wire logic tx_offer_valid,
  input wire logic tx_offer_sel,
  input wire logic [1:0] abort_req,
  input wire logic irq
);
  logic [7:0] ra;
  logic [2:0] hist;
  // Recent engine result or write response
  always_ff @(posedge aclk) begin
    hist <= {hist[1:0], s_axi_bvalid | (|{evt_even[4:1], evt_odd[4:1]})};
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_clear;
    !$past(aresetn) |-> !irq && !tx_offer_valid && abort_req == 2'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("output set after reset");
  property p_rd_upper;
    s_axi_rvalid && ra == `OFS_PAIR_CTRL |-> s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper half not zero");
  property p_rd_unmapped;
    s_axi_rvalid && ra > `OFS_ENGINE |->
      s_axi_rresp == `AXI_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read answered");
  property p_abort_cause;
    $rose(abort_req[0]) |-> s_axi_bvalid || (|hist[1:0]);
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without write");
  property p_abort_drop;
    abort_req[0] && evt_even.aborted |-> ##[1:3] !abort_req[0];
  endproperty
  a_abort_drop: assert property (p_abort_drop)
    else $error("abort request stuck");
  property p_done_clear;
    tx_offer_valid && tx_offer_sel && evt_odd.done_ok && !s_axi_wvalid
      |-> ##[1:3] !(tx_offer_valid && tx_offer_sel);
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("sent buffer still offered");
  property p_irq_cause;
    $rose(irq) |-> |hist;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without cause");
  property p_offer_fall;
    $fell(tx_offer_valid) |-> |hist;
  endproperty
  a_offer_fall: assert property (p_offer_fall)
    else $error("offer dropped without cause");
  c_abort: cover property (abort_req[0] && evt_even.aborted);
  c_odd_offer: cover property (tx_offer_valid && tx_offer_sel);
  c_irq: cover property ($rose(irq));
endmodule : can_buffer_pair_control_sva

bind can_buffer_pair_control can_buffer_pair_control_sva chk (.*);

// file: verif/can_buffer_pair_control_test.sv
// Bus-level test of the buffer pair control block
`include "can_pair_params.svh"
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected %0t %h %h", $time, g, e); \
  end \
end
module can_buffer_pair_control_test
  import can_pair_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] CTRL = `OFS_PAIR_CTRL;
  localparam logic [7:0] STAT = `OFS_IRQ_STATUS;
  localparam logic [7:0] MASK = `OFS_IRQ_MASK;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_offer_valid, tx_offer_sel, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_offer_pri, abort_req, r;
  logic [31:0] s_axi_rdata, d;
  engine_evt_t evt_even, evt_odd;
  logic [3:0] lat = 4'h6;
  logic [1:0] fail = 2'h0;
  logic [1:0] rtr = 2'h0;
  int n_errors = 0;
  int check_count = 0;
  int i;
  always #2.5 aclk = ~aclk;
  can_buffer_pair_control uut (.*);
  can_engine_model engine (.*);
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic give_up;
    n_errors++;
    summarize();
  endtask : give_up
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] v, input logic [3:0] s);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
    {s_axi_arvalid, s_axi_rready} <= {2{!we}};
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (we ? s_axi_bvalid : s_axi_rvalid) break;
    end
    if (k == 50) give_up();
    d = s_axi_rdata;
    r = we ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    xfer(1'h1, a, v, s);
  endtask : wr
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0, 4'h0);
    `CHK(d, e)
  endtask : expect_rd
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int k;
    for (k = 0; k < 60; k++) begin
      xfer(1'h0, a, 32'h0, 4'h0);
      if ((d & m) == m) break;
    end
    if (k == 60) give_up();
  endtask : poll
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    expect_rd(CTRL, 32'h0);
    expect_rd(MASK, 32'h0);
    `CHK(irq, 1'h0)
    // Both buffers queued, odd one at top priority
    wr(MASK, 32'hFF, 4'h1);
    wr(CTRL, 32'h8B89, 4'h3);
    for (i = 0; i < 20 && !tx_offer_valid; i++) @(posedge aclk);
    `CHK(tx_offer_valid, 1'h1)
    `CHK(tx_offer_sel, 1'h1)
    `CHK(tx_offer_pri, 2'h3)
    poll(STAT, 32'h88);
    `CHK(irq, 1'h1)
    expect_rd(CTRL, 32'h8381);
    wr(STAT, 32'h88, 4'h1);
    expect_rd(STAT, 32'h0);
    `CHK(irq, 1'h0)
    wr(MASK, 32'h0, 4'h1);
    // Lost arbitration, then bus error, each ended by abort
    for (i = 0; i < 2; i++) begin
      fail <= 2'(i + 1);
      lat <= 4'(i);
      wr(CTRL, 32'h89, 4'h1);
      poll(CTRL, 32'h20 >> i);
      wr(CTRL, 32'h81, 4'h1);
      poll(CTRL, 32'h40);
      expect_rd(CTRL, 32'h83C1 | (32'h20 >> i));
      expect_rd(STAT, 32'h4 | (32'h2 >> i));
      `CHK(irq, 1'h0)
      wr(MASK, 32'hFF, 4'h1);
      expect_rd(MASK, 32'hFF);
      `CHK(irq, 1'h1)
      wr(STAT, 32'hFF, 4'h1);
      wr(MASK, 32'h0, 4'h1);
    end
    fail <= 2'h0;
    wr(CTRL, 32'h89, 4'h1);
    poll(STAT, 32'h08);
    expect_rd(CTRL, 32'h8381);
    // Receive buffer with auto reply; flag bits are read-only
    wr(CTRL, 32'h74, 4'h1);
    expect_rd(CTRL, 32'h8304);
    rtr <= 2'h3;
    @(posedge aclk);
    rtr <= 2'h0;
    expect_rd(CTRL, 32'h830C);
    `CHK(tx_offer_valid, 1'h0)
    expect_rd(8'h10, 32'h0);
    `CHK(r, `AXI_SLVERR)
    wr(8'h10, 32'h1, 4'hF);
    `CHK(r, `AXI_SLVERR)
    summarize();
  end
endmodule : can_buffer_pair_control_test

// file: verif/can_engine_model.sv
// Behavioural protocol engine serving the buffer pair offers
module can_engine_model
  import can_pair_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Offer from the block
  input wire logic tx_offer_valid,
  input wire logic tx_offer_sel,
  input wire logic [1:0] abort_req,
  // Commands: latency, outcome (0 ok, 1 lost, 2 error), remote frames
  input wire logic [3:0] lat,
  input wire logic [1:0] fail,
  input wire logic [1:0] rtr,
  // Results to the block
  output engine_evt_t evt_even,
  output engine_evt_t evt_odd
);
  logic busy = 1'h0;
  logic who = 1'h0;
  logic [3:0] cnt = 4'h0;
  logic [4:0] res;
  assign res = abort_req[who] ? 5'h08 :
    {fail == 2'h0, 1'h0, fail == 2'h1, fail == 2'h2, 1'h0};
  always_ff @(posedge aclk) begin
    evt_even <= {4'h0, rtr[0]};
    evt_odd <= {4'h0, rtr[1]};
    if (!aresetn) begin
      busy <= 1'h0;
      cnt <= 4'h0;
    end else if (!busy) begin
      // Idle gap lets the offer settle after a result
      if (cnt != 4'h0) cnt <= cnt - 4'h1;
      else if (tx_offer_valid) begin
        busy <= 1'h1;
        who <= tx_offer_sel;
        cnt <= lat;
      end
    end else if (cnt == 4'h0 || abort_req[who]) begin
      busy <= 1'h0;
      cnt <= 4'h4;
      if (who) evt_odd <= {res[4:1], rtr[1]};
      else evt_even <= {res[4:1], rtr[0]};
    end else cnt <= cnt - 4'h1;
  end
endmodule : can_engine_model
